// ### logic/lrpst_pattern_gen.sv
`default_nettype none
module lrpst_pattern_gen
  import lrpst_pkg::*;
(
  // clock and resets
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  // control
  input  wire logic        start,
  input  wire logic        step,
  input  wire lrpst_ctl_t  cfg,
  input  wire logic [23:0] pat_buf,
  // pattern out
  output logic             exp_bit,
  output logic             bit_valid,
  output logic             busy,
  output logic             loop_end,
  output logic             done
);
  lrpst_state_t st_q;
  logic [1:0]   slot_q;
  logic [4:0]   bit_q;
  logic         frame_q;
  logic [6:0]   loop_q;
  logic [5:0]   pass_q;
  logic [2:0]   per_cnt_q;
  logic         per_val_q;
  lrpst_gen_t   gen;
  logic [6:0]   loops;
  logic [2:0]   half_m1;
  logic         skip;
  logic         slot_end;

  // generator type for a slot under the selected order
  function automatic lrpst_gen_t slot_gen(input logic [2:0] ord, input logic [1:0] s);
    lrpst_gen_t seq [3];
    unique case (ord)
      3'h1: seq = '{GEN_STORE, GEN_CONST, GEN_PERIODIC};
      3'h2: seq = '{GEN_PERIODIC, GEN_STORE, GEN_CONST};
      3'h3: seq = '{GEN_PERIODIC, GEN_CONST, GEN_STORE};
      3'h4: seq = '{GEN_CONST, GEN_STORE, GEN_PERIODIC};
      3'h5: seq = '{GEN_CONST, GEN_PERIODIC, GEN_STORE};
      default: seq = '{GEN_STORE, GEN_PERIODIC, GEN_CONST}; // reserved codes act as 000
    endcase
    return (s == 2'd0) ? seq[0] : (s == 2'd1) ? seq[1] : seq[2];
  endfunction

  // current slot's generator, loop count and period
  always_comb begin
    gen = slot_gen(cfg.generator_order, slot_q);
    unique case (gen)
      GEN_STORE:    loops = cfg.pattern_store_loops;
      GEN_PERIODIC: loops = cfg.periodic_gen_loops;
      default:      loops = {2'b00, cfg.constant_gen_loops};
    endcase
    unique case (cfg.periodic_gen_period)
      3'h2:    half_m1 = 3'd1;
      3'h3:    half_m1 = 3'd2;
      3'h4:    half_m1 = 3'd3;
      3'h6:    half_m1 = 3'd5;
      default: half_m1 = 3'd0;
    endcase
  end

  // a zero loop count skips its slot without sending a bit
  assign skip      = (st_q == ST_RUN) && (loops == 7'd0);
  assign bit_valid = (st_q == ST_RUN) && !skip;
  assign slot_end  = skip || (bit_valid && step && bit_q == BIT_LAST && frame_q && loop_q == loops - 7'd1);
  assign loop_end  = slot_end && slot_q == 2'd2;
  assign done      = (loop_end && pass_q == cfg.overall_loop_count - 6'd1) ||
                     (start && cfg.overall_loop_count == 6'd0);
  assign busy      = (st_q == ST_RUN);

  // expected bit before lane inversion
  always_comb begin
    unique case (gen)
      GEN_STORE:    exp_bit = pat_buf[bit_q];
      GEN_PERIODIC: exp_bit = per_val_q;
      default:      exp_bit = cfg.constant_gen_value;
    endcase
  end

  // sequencer: bits, frames, loops, slots, passes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      slot_q    <= 2'd0;
      bit_q     <= 5'd0;
      frame_q   <= 1'b0;
      loop_q    <= 7'd0;
      pass_q    <= 6'd0;
      per_cnt_q <= 3'd0;
      per_val_q <= 1'b0;
    end else if (clear) begin
      st_q <= ST_IDLE;
    end else if (start) begin
      st_q      <= (cfg.overall_loop_count == 6'd0) ? ST_IDLE : ST_RUN;
      slot_q    <= 2'd0;
      bit_q     <= 5'd0;
      frame_q   <= 1'b0;
      loop_q    <= 7'd0;
      pass_q    <= 6'd0;
      per_cnt_q <= 3'd0;
      per_val_q <= 1'b0;
    end else if (slot_end) begin
      bit_q     <= 5'd0;
      frame_q   <= 1'b0;
      loop_q    <= 7'd0;
      per_cnt_q <= 3'd0;
      per_val_q <= 1'b0;
      slot_q    <= loop_end ? 2'd0 : slot_q + 2'd1;
      if (loop_end) begin
        pass_q <= pass_q + 6'd1;
        if (done) begin
          st_q <= ST_IDLE;
        end
      end
    end else if (bit_valid && step) begin
      // two 24-bit frames make one loop
      bit_q <= (bit_q == BIT_LAST) ? 5'd0 : bit_q + 5'd1;
      if (bit_q == BIT_LAST) begin
        frame_q <= ~frame_q;
        if (frame_q) begin
          loop_q <= loop_q + 7'd1;
        end
      end
      per_cnt_q <= (per_cnt_q == half_m1) ? 3'd0 : per_cnt_q + 3'd1;
      if (per_cnt_q == half_m1) begin
        per_val_q <= ~per_val_q;
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/lrpst_pkg.sv
`default_nettype none
package lrpst_pkg;
  // geometry
  localparam int LANES = 14;
  localparam int PORTS = 2;
  localparam int AW    = 12;

  // register byte offsets
  localparam logic [11:0] OFS_RING_A  = 12'h198;
  localparam logic [11:0] OFS_ERR_A   = 12'h19c;
  localparam logic [11:0] OFS_CTL_A   = 12'h1a0;
  localparam logic [11:0] OFS_RING_B  = 12'h298;
  localparam logic [11:0] OFS_ERR_B   = 12'h29c;
  localparam logic [11:0] OFS_CTL_B   = 12'h2a0;
  localparam logic [11:0] OFS_MODE    = 12'h300;
  localparam logic [11:0] OFS_IRQ_ST  = 12'h304;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h308;
  localparam logic [11:0] OFS_RUN_ST  = 12'h30c;

  // pattern generator control word, msb first
  typedef struct packed {
    logic [5:0] overall_loop_count;
    logic [4:0] constant_gen_loops;
    logic       constant_gen_value;
    logic [6:0] periodic_gen_loops;
    logic [2:0] periodic_gen_period;
    logic [6:0] pattern_store_loops;
    logic [2:0] generator_order;
  } lrpst_ctl_t;

  // one receive beat: one bit per lane
  typedef struct packed {
    logic             valid;
    logic [LANES-1:0] lanes;
  } lrpst_rx_t;

  typedef enum logic [1:0] {GEN_STORE, GEN_PERIODIC, GEN_CONST} lrpst_gen_t;
  typedef enum logic {ST_IDLE, ST_RUN} lrpst_state_t;

  // reset values
  localparam lrpst_ctl_t CTL_RST = '{
    overall_loop_count:  6'h04,
    constant_gen_loops:  5'h00,
    constant_gen_value:  1'b0,
    periodic_gen_loops:  7'h19,
    periodic_gen_period: 3'h1,
    pattern_store_loops: 7'h19,
    generator_order:     3'h0
  };
  localparam logic [LANES-1:0] RING_RST    = 14'h0001;
  localparam logic [LANES-1:0] ERR_RST     = 14'h0000;
  localparam logic [23:0]      PAT_BUF_RST = 24'h02ccfd;

  // timing counts
  localparam logic [4:0] BIT_LAST   = 5'd23;
  localparam logic [2:0] PHASE_LAST = 3'd4;

  // mode register fields
  localparam int MODE_START = 0;
  localparam int MODE_SWAP  = 2;
  // irq bits: done per port, then error per port
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR  = 2;
  localparam int IRQ_W    = 4;
endpackage
`default_nettype wire

// ### logic/lrpst_top.sv
`default_nettype none
module lrpst_top
  import lrpst_pkg::*;
(
  // clock and resets
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        warm_rst,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // receive lanes per port
  input  wire lrpst_rx_t   rx_a,
  input  wire lrpst_rx_t   rx_b,
  // interrupt
  output logic             irq
);
  // registers: ring, error, control and phase one set per port; mode, irq and read data shared
  logic [LANES-1:0] ring_q [PORTS];
  logic [LANES-1:0] err_q  [PORTS];
  lrpst_ctl_t       ctl_q  [PORTS];
  logic [1:0]       swap_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_msk_q;
  logic [2:0]       phase_q [PORTS];
  logic [31:0]      prdata_q;

  // generator side
  lrpst_rx_t        rx [PORTS];
  logic [PORTS-1:0] start;
  logic [PORTS-1:0] exp_bit;
  logic [PORTS-1:0] bit_valid;
  logic [PORTS-1:0] busy;
  logic [PORTS-1:0] loop_end;
  logic [PORTS-1:0] done;
  logic [PORTS-1:0] chk;
  logic [LANES-1:0] miss [PORTS];
  logic [PORTS-1:0] new_err;

  // bus decode
  logic        wr_en;
  logic        setup;
  logic        hit;
  logic [31:0] rd_mux;
  logic [PORTS-1:0] wr_ring;
  logic [PORTS-1:0] wr_ctl;

  assign rx[0] = rx_a;
  assign rx[1] = rx_b;

  // access phase completes at once; setup cycle registers read data
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = prdata_q;

  assign wr_ring[0] = wr_en && paddr == OFS_RING_A;
  assign wr_ring[1] = wr_en && paddr == OFS_RING_B;
  assign wr_ctl[0]  = wr_en && paddr == OFS_CTL_A;
  assign wr_ctl[1]  = wr_en && paddr == OFS_CTL_B;

  // start pulses come from the mode register write
  assign start = (wr_en && paddr == OFS_MODE) ? pwdata[MODE_START +: PORTS] : '0;

  // read mux; unmapped offsets read zero and flag pslverr
  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFS_RING_A:  rd_mux = {18'h0, ring_q[0]};
      OFS_ERR_A:   rd_mux = {18'h0, err_q[0]};
      OFS_CTL_A:   rd_mux = ctl_q[0];
      OFS_RING_B:  rd_mux = {18'h0, ring_q[1]};
      OFS_ERR_B:   rd_mux = {18'h0, err_q[1]};
      OFS_CTL_B:   rd_mux = ctl_q[1];
      OFS_MODE:    rd_mux = {28'h0, swap_q, 2'b00};
      OFS_IRQ_ST:  rd_mux = {28'h0, irq_st_q};
      OFS_IRQ_MSK: rd_mux = {28'h0, irq_msk_q};
      OFS_RUN_ST:  rd_mux = {30'h0, busy};
      default:     hit = 1'b0;
    endcase
  end

  // read data is captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  // one generator per port
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    lrpst_pattern_gen u_gen (
      .clk       (pclk),
      .rst_n     (presetn),
      .clear     (warm_rst),
      .start     (start[p]),
      .step      (rx[p].valid),
      .cfg       (ctl_q[p]),
      .pat_buf   (PAT_BUF_RST),
      .exp_bit   (exp_bit[p]),
      .bit_valid (bit_valid[p]),
      .busy      (busy[p]),
      .loop_end  (loop_end[p]),
      .done      (done[p])
    );

    // compare only the lanes of the current modulo-5 subgroup
    assign chk[p] = rx[p].valid && bit_valid[p];
    for (genvar l = 0; l < LANES; l++) begin : g_lane
      assign miss[p][l] = chk[p] && (3'(l % 5) == phase_q[p]) &&
                          (rx[p].lanes[l] != (exp_bit[p] ^ ring_q[p][l]));
    end
    assign new_err[p] = |(miss[p] & ~err_q[p]);
  end

  // subgroup phase walks 0..4 on every checked beat
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < PORTS; p++) begin
        phase_q[p] <= 3'd0;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (warm_rst || start[p]) begin
          phase_q[p] <= 3'd0;
        end else if (chk[p]) begin
          phase_q[p] <= (phase_q[p] == PHASE_LAST) ? 3'd0 : phase_q[p] + 3'd1;
        end
      end
    end
  end

  // inversion ring: write loads, end of pass rotates left
  // warm reset leaves it alone so a failing lane can be read back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < PORTS; p++) begin
        ring_q[p] <= RING_RST;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (loop_end[p]) begin
          ring_q[p] <= {ring_q[p][LANES-2:0], ring_q[p][LANES-1]};
        end else if (wr_ring[p]) begin
          ring_q[p] <= pwdata[LANES-1:0];
        end
      end
    end
  end

  // lane error status: sticky, read only, cleared by a new start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < PORTS; p++) begin
        err_q[p] <= ERR_RST;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (start[p]) begin
          err_q[p] <= ERR_RST;
        end else begin
          err_q[p][LANES-2:0] <= err_q[p][LANES-2:0] | miss[p][LANES-2:0];
          err_q[p][LANES-1]   <= err_q[p][LANES-1] | miss[p][LANES-1];
        end
      end
    end
  end

  // generator control words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < PORTS; p++) begin
        ctl_q[p] <= CTL_RST;
      end
    end else begin
      for (int p = 0; p < PORTS; p++) begin
        if (wr_ctl[p]) begin
          ctl_q[p] <= pwdata;
        end
      end
    end
  end

  // swap mode is stored for software only; the ring ignores it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swap_q <= 2'b00;
    end else if (wr_en && paddr == OFS_MODE) begin
      swap_q <= pwdata[MODE_SWAP +: PORTS];
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_msk_q <= '0;
    end else if (warm_rst) begin
      irq_msk_q <= '0;
    end else if (wr_en && paddr == OFS_IRQ_MSK) begin
      irq_msk_q <= pwdata[IRQ_W-1:0];
    end
  end

  // interrupt status: write one clears, a same-cycle event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_q <= '0;
    end else if (warm_rst) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~((wr_en && paddr == OFS_IRQ_ST) ? pwdata[IRQ_W-1:0] : '0))
                | {new_err, done};
    end
  end

  // level interrupt while any unmasked status bit is set
  assign irq = |(irq_st_q & irq_msk_q);

endmodule
`default_nettype wire

// ### verification/lrpst_checker.sv
`default_nettype none
module lrpst_checker
  import lrpst_pkg::*;
(
  // clock and resets
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        warm_rst,
  // apb
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // link and interrupt
  input wire lrpst_rx_t   rx_a,
  input wire lrpst_rx_t   rx_b,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read setup cycle, when prdata is captured
  wire rd_su = psel && !penable && !pwrite;

  // bus answers
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access without pready");
  property p_err_ph; pslverr |-> psel && penable; endproperty
  a_err_ph: assert property (p_err_ph) else $error("pslverr outside access");
  property p_map_ok; psel && penable && paddr == OFS_CTL_B |-> !pslverr; endproperty
  a_map_ok: assert property (p_map_ok) else $error("pslverr on mapped address");
  property p_hold; !rd_su |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("prdata moved without read");
  property p_unmap; rd_su && paddr == 12'h0f0 |=> prdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // register contents, and irq after warm reset
  property p_start_rd; rd_su && paddr == OFS_MODE |=> prdata[1:0] == 2'h0; endproperty
  a_start_rd: assert property (p_start_rd) else $error("start bits read back");
  property p_err_rsv; rd_su && paddr == OFS_ERR_A |=> prdata[31:14] == 18'h0; endproperty
  a_err_rsv: assert property (p_err_rsv) else $error("error reserved bits set");
  property p_warm; warm_rst |=> !irq; endproperty
  a_warm: assert property (p_warm) else $error("irq after warm reset");

  // main scenarios
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (pslverr);
  c_beats: cover property (rx_a.valid ##1 rx_b.valid);
endmodule
`default_nettype wire

// ### verification/lrpst_link_partner.sv
`default_nettype none
module lrpst_link_partner
  import lrpst_pkg::*;
(
  // clock
  input  wire logic             pclk,
  // beat control
  input  wire logic             en,
  input  wire logic             slow,
  input  wire logic             value,
  input  wire logic [1:0]       kind,
  input  wire logic [2:0]       per,
  input  wire logic [7:0]       plen,
  input  wire logic [LANES-1:0] ring,
  input  wire logic [LANES-1:0] flip,
  // link out
  output lrpst_rx_t             rx
);
  logic       tog = 1'b0;
  logic       beat;
  logic       b;
  logic [7:0] n   = 8'h00; // beats since enable
  logic [4:0] k   = 5'h00; // bit of the 24-bit frame
  logic [2:0] h   = 3'h0;  // bits sent at the current level
  logic       pv  = 1'b0;  // square wave level, starts low
  initial rx = '0;
  assign beat = en && (!slow || tog);
  // kind 1 sends the stored word lsb first, kind 2 a square wave; constant level once plen beats are out
  always_comb begin
    b = value;
    if (n < plen && kind == 2'h1) b = PAT_BUF_RST[k];
    if (n < plen && kind == 2'h2) b = pv;
  end
  // slow mode beats every other cycle; idle lanes churn so stale data never matches
  always @(posedge pclk) begin
    tog      <= !tog;
    rx.valid <= beat;
    rx.lanes <= beat ? ({LANES{b}} ^ ring ^ flip) : {LANES{tog}};
    if (!en) begin
      n  <= 8'h00;
      k  <= 5'h00;
      h  <= 3'h0;
      pv <= 1'b0;
    end else if (beat) begin
      n <= (n == 8'hff) ? n : n + 8'h01;
      k <= (k == 5'h17) ? 5'h00 : k + 5'h01;
      if (h + 3'h1 == per) begin
        h  <= 3'h0;
        pv <= !pv;
      end else begin
        h <= h + 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/lrpst_top_tb.sv
`default_nettype none
module lrpst_top_tb
  import lrpst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, warm_rst = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serr, irq, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat, swap = 32'h0;
  logic [1:0]  en_m = 2'b0, val_m = 2'b0, slow_m = 2'b0;
  logic [13:0] ring_m [2] = '{14'h1, 14'h1};
  logic [13:0] flip_m [2] = '{14'h0, 14'h0};
  logic [1:0]  kind_m [2] = '{2'h0, 2'h0};
  logic [2:0]  per_m  [2] = '{3'h1, 3'h1};
  lrpst_rx_t   rx_a, rx_b;
  int          errors = 0, tests_run = 0;

  lrpst_top i_lrpst_top (.pclk(pclk), .presetn(presetn), .warm_rst(warm_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_a(rx_a), .rx_b(rx_b), .irq(irq));
  // pattern length 30h: one loop of two 24-bit frames
  lrpst_link_partner i_lrpst_link_partner_a (.pclk(pclk), .en(en_m[0]), .slow(slow_m[0]),
    .value(val_m[0]), .kind(kind_m[0]), .per(per_m[0]), .plen(8'h30), .ring(ring_m[0]), .flip(flip_m[0]),
    .rx(rx_a));
  lrpst_link_partner i_lrpst_link_partner_b (.pclk(pclk), .en(en_m[1]), .slow(slow_m[1]),
    .value(val_m[1]), .kind(kind_m[1]), .per(per_m[1]), .plen(8'h30), .ring(ring_m[1]), .flip(flip_m[1]),
    .rx(rx_b));

  // clock, and a watchdog well beyond the expected run
  initial forever #20 pclk = ~pclk;
  initial begin
    repeat (60000) @(posedge pclk);
    errors++;
    summarize();
  end

  // one apb transfer; waits for pready rather than assuming zero wait states
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  function automatic logic [31:0] mk(input logic [5:0] o, input logic [4:0] c, input logic v, input logic [2:0] g);
    return {o, c, v, 7'h00, 3'h1, 7'h00, g};
  endfunction
  // one pass, one constant loop, chosen periodic and stored loop counts
  function automatic logic [31:0] mkp(input logic v, input logic [6:0] m, input logic [2:0] pc, input logic [6:0] s,
    input logic [2:0] g);
    return {6'h01, 5'h01, v, m, pc, s, g};
  endfunction
  // one self-test run on port p for the passes set in ctl, partner feeding the kind_m pattern
  task run(input int p, input logic [31:0] ctl, input logic v, input logic [13:0] fl, input logic sl);
    int n;
    apb(1'b1, p ? OFS_CTL_B : OFS_CTL_A, ctl);
    apb(1'b0, p ? OFS_RING_B : OFS_RING_A, 32'h0);
    ring_m[p] <= rdat[13:0];
    flip_m[p] <= fl;
    val_m[p] <= v;
    slow_m[p] <= sl;
    // beats start after the start write so the partner's bit count lines up with the generator
    apb(1'b1, OFS_MODE, swap | (32'h1 << p));
    en_m[p] <= 1'b1;
    n = 0;
    do begin
      apb(1'b0, OFS_IRQ_ST, 32'h0);
      n++;
    end while (rdat[IRQ_DONE + p] !== 1'b1 && n < 400);
    chk({31'h0, rdat[IRQ_DONE + p]}, 32'h1);
    en_m[p] <= 1'b0;
    apb(1'b1, OFS_IRQ_ST, 32'h1 << (IRQ_DONE + p));
  endtask

  task t_reset();
    rd(OFS_RING_A, 32'h1);
    rd(OFS_ERR_A, 32'h0);
    rd(OFS_CTL_A, 32'h100324c8);
    rd(OFS_RING_B, 32'h1);
    rd(OFS_ERR_B, 32'h0);
    rd(OFS_CTL_B, 32'h100324c8);
    rd(12'h0f0, 32'h0);
    chk({31'h0, serr}, 32'h1);
  endtask
  task t_rw();
    apb(1'b1, OFS_RING_A, 32'hffff2a55);
    rd(OFS_RING_A, 32'h2a55);
    apb(1'b1, OFS_ERR_A, 32'h3fff);
    rd(OFS_ERR_A, 32'h0);
    apb(1'b1, OFS_CTL_A, 32'h55555555);
    rd(OFS_CTL_A, 32'h55555555);
  endtask
  // all six orders, both constant values, swap mode on and off
  task t_orders();
    logic [13:0] e;
    e = 14'h0001;
    apb(1'b1, OFS_RING_A, 32'h1);
    for (int o = 0; o < 6; o++) begin
      swap = (o > 2) ? 32'h4 : 32'h0;
      run(0, mk(6'h01, 5'h01, o[0], o[2:0]), o[0], 14'h0, o[1]);
      e = {e[12:0], e[13]};
      rd(OFS_ERR_A, 32'h0);
      rd(OFS_RING_A, {18'h0, e});
    end
    apb(1'b1, OFS_RING_A, 32'h2000);
    run(0, mk(6'h01, 5'h01, 1'b0, 3'h0), 1'b0, 14'h0, 1'b0);
    rd(OFS_RING_A, 32'h1);
    rd(OFS_MODE, 32'h4);
  endtask
  task t_err();
    apb(1'b1, OFS_IRQ_MSK, 32'h8);
    run(1, mk(6'h01, 5'h01, 1'b1, 3'h2), 1'b1, 14'h2009, 1'b1);
    rd(OFS_ERR_B, 32'h2009);
    rd(OFS_RING_B, 32'h2);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFS_IRQ_ST, 32'h8);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  // warm reset keeps sticky fields, drops the irq mask
  task t_warm();
    @(posedge pclk);
    warm_rst <= 1'b1;
    @(posedge pclk);
    warm_rst <= 1'b0;
    rd(OFS_ERR_B, 32'h2009);
    rd(OFS_CTL_B, mk(6'h01, 5'h01, 1'b1, 3'h2));
    rd(OFS_IRQ_MSK, 32'h0);
  endtask
  task t_zero();
    run(0, mk(6'h00, 5'h01, 1'b0, 3'h0), 1'b0, 14'h0, 1'b0);
    rd(OFS_RING_A, 32'h1);
    run(0, mk(6'h02, 5'h01, 1'b0, 3'h0), 1'b0, 14'h0, 1'b1);
    rd(OFS_RING_A, 32'h4);
    rd(OFS_RUN_ST, 32'h0);
  endtask
  // stored word then square waves, each running straight into the constant slot
  task t_pat();
    kind_m[0] <= 2'h1;
    run(0, mkp(1'b1, 7'h00, 3'h1, 7'h01, 3'h1), 1'b1, 14'h0, 1'b0);
    rd(OFS_ERR_A, 32'h0);
    kind_m[0] <= 2'h2;
    for (int i = 1; i <= 6; i++) begin
      if (i != 5) begin
        per_m[0] <= 3'(i);
        run(0, mkp(i[0], 7'h01, 3'(i), 7'h00, 3'h3), i[0], 14'h0, i[1]);
        rd(OFS_ERR_A, 32'h0);
      end
    end
    kind_m[0] <= 2'h0;
  endtask

  task summarize();
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_rw();
    t_orders();
    t_err();
    t_warm();
    t_zero();
    t_pat();
    summarize();
  end
endmodule
bind lrpst_top lrpst_checker i_lrpst_checker (.pclk(pclk), .presetn(presetn), .warm_rst(warm_rst),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_a(rx_a), .rx_b(rx_b), .irq(irq));
`default_nettype wire
